// >>> tb/mlpic_gen.sv
// Pattern generator model driving the pulser gate and sample clock pins.
// Assumes bench patterns are active high in the gate struct order.
`timescale 1ns/1ps
module mlpic_gen
  import mlpic_pkg::*;
(
  // Clock and reset
  input  wire logic          clk_i,
  input  wire logic          nrst_i,
  // Bench control
  input  wire logic          power_on_select_i,
  input  wire logic          enable_n_i,
  input  wire logic          bad_i,
  input  wire logic [11:0]   pattern_i,
  // Pins
  output mlpic_gates_t       gates_o,
  output logic               sample_clock_o
);
  // Bad mode stops the clock and skips inversion and idling
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sample_clock_o <= 1'b0;
    end else if (!enable_n_i && !bad_i) begin
      sample_clock_o <= ~sample_clock_o;
    end else begin
      sample_clock_o <= 1'b0;
    end
  end
  always_comb begin
    if (bad_i) begin
      gates_o = mlpic_gates_t'(pattern_i);
    end else if (!power_on_select_i) begin
      gates_o = GATES_IDLE;
    end else begin
      gates_o = mlpic_gates_t'(pattern_i ^ 12'hE38);
    end
  end
endmodule // mlpic_gen

// >>> tb/tb.sv
// Self-checking bench for the pulser input control block.
// Assumes the generator model drives gates and sample clock.
`timescale 1ns/1ps
module tb;
  import mlpic_pkg::*;
  logic clk_i = 1'b0, nrst_i = 1'b0, en_n = 1'b1, pwr = 1'b0;
  logic cwa = 1'b0, cwb = 1'b0, bad = 1'b0, lvl_v = 1'b0;
  logic [4:0]   lvl = 5'h00;
  logic [11:0]  pat = 12'h000;
  logic         sclk, rdy, hiz, cwo_a, cwo_b, f_sh, f_pw, f_ck;
  mlpic_gates_t gates, stage;
  mlpic_mode_t  mode;
  int           n_fail = 0, num_checks = 0;
  // Active-high table, codes 0..16 = +8..-8
  logic [11:0] lut [0:16] = '{12'h402, 12'h404, 12'h409, 12'h802,
    12'h804, 12'h809, 12'h242, 12'h244, 12'h249, 12'h109, 12'h089,
    12'h260, 12'h120, 12'h0A0, 12'h250, 12'h110, 12'h090};
  logic [3:0]  mv [0:4] = '{4'h8, 4'hA, 4'h1, 4'hC, 4'h4};
  mlpic_mode_t me [0:4] = '{MLPIC_PWRDN, MLPIC_CW, MLPIC_CW,
    MLPIC_NOLAT, MLPIC_LATCH};

  always #50 clk_i = ~clk_i;

  mlpic_gen i_mlpic_gen (.clk_i(clk_i), .nrst_i(nrst_i),
    .power_on_select_i(pwr), .enable_n_i(en_n), .bad_i(bad),
    .pattern_i(pat), .gates_o(gates), .sample_clock_o(sclk));
  mlpic_ctrl i_mlpic_ctrl (.clk_i(clk_i), .nrst_i(nrst_i),
    .enable_n_i(en_n), .power_on_select_i(pwr),
    .sample_clock_in_i(sclk), .cw_drive_a_i(cwa), .cw_drive_b_i(cwb),
    .gates_i(gates), .level_valid_i(lvl_v), .level_ready_o(rdy),
    .level_i(lvl), .mode_o(mode), .stage_o(stage),
    .outputs_hiz_o(hiz), .cw_a_o(cwo_a), .cw_b_o(cwo_b),
    .fault_shoot_o(f_sh), .fault_power_o(f_pw), .fault_clock_o(f_ck));

  task automatic chk_g(input string nm, input mlpic_gates_t e, g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic chk_b(input string nm, input logic e, g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s exp %b got %b", nm, e, g);
    end
  endtask
  task automatic chk_m(input string nm, input mlpic_mode_t e, g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  function automatic mlpic_gates_t pin(input logic [11:0] a);
    return mlpic_gates_t'(a ^ 12'hE38);
  endfunction
  task automatic end_sim;
    if (n_fail == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    #(400 * 100);
    n_fail++;
    end_sim();
  end

  initial begin
    cyc(20);
    nrst_i <= 1'b1;
    #10 chk_g("reset stage", GATES_IDLE, stage);
    chk_b("reset shoot", 1'b0, f_sh);
    for (int i = 0; i < 5; i++) begin
      @(posedge clk_i) {en_n, pwr, cwa, cwb} <= mv[i];
      cyc(3);
      #10 chk_m("mode", me[i], mode);
      chk_b("hiz", i == 0, hiz);
      if (me[i] == MLPIC_CW) begin
        chk_b("cw a", cwa, cwo_a);
        chk_b("cw b", cwb, cwo_b);
      end
    end
    // Latch mode: sample clock runs, pattern held six cycles
    foreach (mv[k]) begin
      @(posedge clk_i) pat <= lut[k * 4];
      cyc(6);
      #10 chk_g("latch", pin(lut[k * 4]), stage);
    end
    chk_b("clock fault", 1'b0, f_ck);
    // Non-latch level stream, one code per cycle, then off codes
    @(posedge clk_i) en_n <= 1'b1;
    lvl_v <= 1'b1;
    for (int i = 0; i < 24; i++) begin
      @(posedge clk_i) lvl <= 5'(i);
      #10 if (i >= 2) chk_g("level", (i < 19) ? pin(lut[i - 2])
        : GATES_IDLE, stage);
    end
    chk_b("ready", 1'b1, rdy);
    @(posedge clk_i) lvl_v <= 1'b0;
    bad <= 1'b1;
    pat <= 12'h1C0;
    cyc(4);
    #10 chk_b("shoot fault", 1'b1, f_sh);
    @(posedge clk_i) pwr <= 1'b0;
    #10 chk_b("power fault", 1'b1, f_pw);
    @(posedge clk_i) pwr <= 1'b1;
    en_n <= 1'b0;
    cyc(20);
    #10 chk_b("clock fault", 1'b1, f_ck);
    @(posedge clk_i) nrst_i <= 1'b0;
    bad <= 1'b0;
    cyc(2);
    #10 chk_g("rereset stage", GATES_IDLE, stage);
    chk_b("rereset shoot", 1'b0, f_sh);
    end_sim();
  end
endmodule // tb

// >>> verilog/mlpic_buf2.sv
// Two-entry valid/ready buffer for gate patterns.
// Assumes a single clock; stalls propagate to the source via in_ready_o.
`timescale 1ns/1ps
module mlpic_buf2
  import mlpic_pkg::*;
(
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         nrst_i,
  // Fill side
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire mlpic_gates_t in_data_i,
  // Drain side
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output mlpic_gates_t      out_data_o
);

  mlpic_gates_t mem_r [BUF_DEPTH];
  mlpic_gates_t mem_nxt [BUF_DEPTH];
  logic         wp_r, wp_nxt, rp_r, rp_nxt;
  logic [1:0]   cnt_r, cnt_nxt;
  logic         push, pop;

  assign in_ready_o  = (cnt_r != 2'h2);
  assign out_valid_o = (cnt_r != 2'h0);
  assign out_data_o  = mem_r[rp_r];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_comb begin
    mem_nxt = mem_r;
    wp_nxt  = wp_r;
    rp_nxt  = rp_r;
    cnt_nxt = cnt_r;
    if (push) begin
      mem_nxt[wp_r] = in_data_i;
      wp_nxt        = ~wp_r;
    end
    if (pop) begin
      rp_nxt = ~rp_r;
    end
    if (push && !pop) begin
      cnt_nxt = cnt_r + 2'h1;
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - 2'h1;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mem_r[0] <= GATES_IDLE;
      mem_r[1] <= GATES_IDLE;
      wp_r     <= 1'b0;
      rp_r     <= 1'b0;
      cnt_r    <= 2'h0;
    end else begin
      mem_r <= mem_nxt;
      wp_r  <= wp_nxt;
      rp_r  <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  a_buf_no_overflow: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (cnt_r == 2'h2 && in_valid_i && !pop) |=> cnt_r == 2'h2)
    else $error("buffer count changed while full");

endmodule // mlpic_buf2

// >>> verilog/mlpic_ctrl.sv
// Input control of a dual-output multi-level pulser: mode decode,
// latch-mode capture, level decode and output gate drive.
// Assumes pins synchronous to clk_i; sample clock is sampled as data.
`timescale 1ns/1ps
module mlpic_ctrl
  import mlpic_pkg::*;
(
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         nrst_i,
  // Mode pins
  input  wire logic         enable_n_i,
  input  wire logic         power_on_select_i,
  input  wire logic         sample_clock_in_i,
  input  wire logic         cw_drive_a_i,
  input  wire logic         cw_drive_b_i,
  // Gate inputs, pin polarity (high side active low)
  input  wire mlpic_gates_t gates_i,
  // Optional level stream, decoded into gates (0..16 = +8..-8)
  input  wire logic         level_valid_i,
  output logic              level_ready_o,
  input  wire logic [4:0]   level_i,
  // Output stage drive
  output mlpic_mode_t       mode_o,
  output mlpic_gates_t      stage_o,
  output logic              outputs_hiz_o,
  output logic              cw_a_o,
  output logic              cw_b_o,
  output logic              fault_shoot_o,
  output logic              fault_power_o,
  output logic              fault_clock_o
);

  mlpic_mode_t  mode;
  mlpic_gates_t level_gates, src_gates, buf_gates, stage_nxt;
  mlpic_gates_t stage_r;
  logic         clk_prev_r, clk_prev_nxt, edge_seen;
  logic         buf_in_valid, buf_in_ready, buf_out_valid, buf_pop;
  logic [3:0]   stuck_r, stuck_nxt;
  logic         shoot, pwr;

  // Mode decode; power select low with equal CW drives is power-down
  always_comb begin
    if (!power_on_select_i) begin
      mode = (cw_drive_a_i ^ cw_drive_b_i) ? MLPIC_CW : MLPIC_PWRDN;
    end else if (enable_n_i) begin
      mode = MLPIC_NOLAT;
    end else begin
      mode = MLPIC_LATCH;
    end
  end

  // Level to pin pattern, high side already inverted
  function automatic mlpic_gates_t lvl2gates(input logic [4:0] l);
    logic [2:0] ap, an, bp, bn;
    ap = 3'h0;
    an = 3'h0;
    bp = 3'h0;
    bn = 3'h0;
    unique case (l)
      5'h00: begin
        ap = 3'h2;
        bn = 3'h2;
      end
      5'h01: begin
        ap = 3'h2;
        bn = 3'h4;
      end
      5'h02: begin
        ap = 3'h2;
        bp = 3'h1;
        bn = 3'h1;
      end
      5'h03: begin
        ap = 3'h4;
        bn = 3'h2;
      end
      5'h04: begin
        ap = 3'h4;
        bn = 3'h4;
      end
      5'h05: begin
        ap = 3'h4;
        bp = 3'h1;
        bn = 3'h1;
      end
      5'h06: begin
        ap = 3'h1;
        an = 3'h1;
        bn = 3'h2;
      end
      5'h07: begin
        ap = 3'h1;
        an = 3'h1;
        bn = 3'h4;
      end
      5'h08: begin
        ap = 3'h1;
        an = 3'h1;
        bp = 3'h1;
        bn = 3'h1;
      end
      5'h09: begin
        bp = 3'h1;
        an = 3'h4;
        bn = 3'h1;
      end
      5'h0A: begin
        bp = 3'h1;
        an = 3'h2;
        bn = 3'h1;
      end
      5'h0B: begin
        ap = 3'h1;
        bp = 3'h4;
        an = 3'h1;
      end
      5'h0C: begin
        bp = 3'h4;
        an = 3'h4;
      end
      5'h0D: begin
        bp = 3'h4;
        an = 3'h2;
      end
      5'h0E: begin
        ap = 3'h1;
        bp = 3'h2;
        an = 3'h1;
      end
      5'h0F: begin
        bp = 3'h2;
        an = 3'h4;
      end
      5'h10: begin
        bp = 3'h2;
        an = 3'h2;
      end
      default: ;
    endcase
    lvl2gates = '{a: '{~ap, an}, b: '{~bp, bn}};
  endfunction

  assign level_gates = lvl2gates(level_i);
  assign src_gates   = level_valid_i ? level_gates : gates_i;
  assign edge_seen   = sample_clock_in_i && !clk_prev_r;

  // Non-latch: every cycle; latch: only on sample clock rising edge
  assign buf_in_valid  = (mode == MLPIC_LATCH) ? edge_seen :
                         (mode == MLPIC_NOLAT);
  assign level_ready_o = buf_in_ready;
  assign buf_pop       = buf_out_valid;

  mlpic_buf2 u_buf (
    .clk_i       (clk_i),
    .nrst_i      (nrst_i),
    .in_valid_i  (buf_in_valid),
    .in_ready_o  (buf_in_ready),
    .in_data_i   (src_gates),
    .out_valid_o (buf_out_valid),
    .out_ready_i (1'b1),
    .out_data_o  (buf_gates)
  );

  always_comb begin
    stage_nxt    = stage_r;
    clk_prev_nxt = sample_clock_in_i;
    stuck_nxt    = stuck_r;
    if (mode == MLPIC_PWRDN || mode == MLPIC_CW) begin
      stage_nxt = GATES_IDLE;
    end else if (buf_pop) begin
      stage_nxt = buf_gates;
    end
    if (mode == MLPIC_LATCH && !sample_clock_in_i) begin
      if (stuck_r != STUCK_LIMIT) begin
        stuck_nxt = stuck_r + 4'h1;
      end
    end else begin
      stuck_nxt = 4'h0;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      stage_r    <= GATES_IDLE;
      clk_prev_r <= 1'b0;
      stuck_r    <= 4'h0;
    end else begin
      stage_r    <= stage_nxt;
      clk_prev_r <= clk_prev_nxt;
      stuck_r    <= stuck_nxt;
    end
  end

  // Fault flags report misuse by the source
  assign shoot = |(~stage_r.a.high_side_gate_in & stage_r.a.low_side_gate_in)
               | |(~stage_r.b.high_side_gate_in & stage_r.b.low_side_gate_in);
  assign pwr   = !power_on_select_i && (gates_i != GATES_IDLE);

  assign mode_o        = mode;
  assign stage_o       = stage_r;
  assign outputs_hiz_o = (mode == MLPIC_PWRDN);
  assign cw_a_o        = (mode == MLPIC_CW) && cw_drive_a_i;
  assign cw_b_o        = (mode == MLPIC_CW) && cw_drive_b_i;
  assign fault_shoot_o = shoot;
  assign fault_power_o = pwr;
  assign fault_clock_o = (stuck_r == STUCK_LIMIT);

  a_latch_capture: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    (mode == MLPIC_LATCH && edge_seen && !level_valid_i
     && $stable(mode)) ##1 (mode == MLPIC_LATCH)
    |=> stage_r == $past(gates_i, 2))
    else $error("latched pattern not on stage");
  a_latch_hold: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    (mode == MLPIC_LATCH && !buf_out_valid) |=> $stable(stage_r))
    else $error("stage changed without sample edge");
  a_mode_pwrdn: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    (!power_on_select_i && cw_drive_a_i == cw_drive_b_i)
    |-> outputs_hiz_o && mode_o == MLPIC_PWRDN)
    else $error("power-down not decoded");
  a_mode_latch: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    (power_on_select_i && !enable_n_i) |-> mode_o == MLPIC_LATCH)
    else $error("latch mode not decoded");
  a_idle_stage: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    !power_on_select_i |=> stage_r == GATES_IDLE)
    else $error("stage not idle in low-power modes");
  a_level_top: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    (level_i == 5'h00) |-> level_gates.a.high_side_gate_in == 3'h5
    && level_gates.b.low_side_gate_in == 3'h2)
    else $error("level +8 pattern wrong");
  a_level_safe: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    (level_i >= LEVEL_OFF) |-> level_gates == GATES_IDLE)
    else $error("off level not idle");
  a_nolatch_rate: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    (mode == MLPIC_NOLAT && $past(mode) == MLPIC_NOLAT && level_valid_i)
    ##1 (mode == MLPIC_NOLAT) |=> stage_r == $past(level_gates, 2))
    else $error("level not applied after two cycles");
  a_clock_stuck: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    (mode == MLPIC_LATCH && !sample_clock_in_i)[*8] |-> stuck_r >= 4'h7)
    else $error("stuck sample clock not counted");

endmodule // mlpic_ctrl

// >>> verilog/mlpic_pkg.sv
// Shared constants and carriers for the pulser input control block.
// Assumes one 10 MHz clock; all pins synchronous to it.
package mlpic_pkg;

  localparam int unsigned CLK_PERIOD_NS   = 100;
  localparam int unsigned OUT_DELAY_NS    = 23;
  // Output delay rounds down to whole cycles, never below one
  localparam int unsigned OUT_DELAY_CYC   =
    (OUT_DELAY_NS / CLK_PERIOD_NS) < 1 ? 1 : (OUT_DELAY_NS / CLK_PERIOD_NS);
  localparam int unsigned MIN_PULSE_NS    = 10;
  localparam int unsigned BUF_DEPTH       = 2;

  localparam logic [2:0] RST_RAIL_HI      = 3'h7;
  localparam logic [2:0] RST_RAIL_LO      = 3'h0;
  localparam logic [4:0] LEVEL_OFF        = 5'h11;
  localparam int unsigned NUM_LEVELS      = 17;
  // Latch-mode cycles with sample clock low that raise the stuck flag
  localparam logic [3:0]  STUCK_LIMIT     = 4'hF;

  // Operating modes, one-hot
  typedef enum logic [3:0] {
    MLPIC_PWRDN  = 4'h1,
    MLPIC_CW     = 4'h2,
    MLPIC_NOLAT  = 4'h4,
    MLPIC_LATCH  = 4'h8
  } mlpic_mode_t;

  // Gate pattern of one output: bit index = rail 0..2
  typedef struct packed {
    logic [2:0] high_side_gate_in;
    logic [2:0] low_side_gate_in;
  } mlpic_chan_t;

  typedef struct packed {
    mlpic_chan_t a;
    mlpic_chan_t b;
  } mlpic_gates_t;

  localparam mlpic_gates_t GATES_IDLE =
    '{a: '{RST_RAIL_HI, RST_RAIL_LO}, b: '{RST_RAIL_HI, RST_RAIL_LO}};

endpackage
